// ### logic/csr_sensor_top.sv
`timescale 1ns/100ps
`include "csr_defines.svh"
module csr_sensor_top #(
    parameter int TICK_CYCLES = `CLK_MHZ * `TICK_US
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [3:0] lightPulse,
    output logic            measuring
);
    import csr_pkg::*;

    csr_link_regs_t r;
    csr_link_regs_t next_r;
    logic [1:0]     pinSync;
    logic           scl;
    logic           sda;
    logic           sclRise;
    logic           sclFall;
    logic           busStart;
    logic           busStop;
    logic [15:0]    redResult;
    logic [15:0]    greenResult;
    logic [15:0]    blueResult;
    logic [15:0]    whiteResult;
    logic           measDone;
    logic           measBusy;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and bus conditions

    csr_pin_sync u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pinIn   ({sclIn, sdaIn}),
        .pinSync (pinSync)
    );

    assign scl      = pinSync[1];
    assign sda      = pinSync[0];
    assign sclRise  = scl && !r.sclPrev;
    assign sclFall  = !scl && r.sclPrev;
    assign busStart = scl && r.sclPrev && r.sdaPrev && !sda;
    assign busStop  = scl && r.sclPrev && !r.sdaPrev && sda;

    ////////////////////////////////////////////////////////////////////////
    // measurement engine

    csr_meas_engine #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_meas (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .shutdown    (r.cfg.sensor_shutdown),
        .forced      (r.cfg.forced_mode_sel),
        .itSel       (r.cfg.integration_time_sel),
        .trigPulse   (r.trigPulse),
        .lightPulse  (lightPulse),
        .redResult   (redResult),
        .greenResult (greenResult),
        .blueResult  (blueResult),
        .whiteResult (whiteResult),
        .measDone    (measDone),
        .measBusy    (measBusy)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read map

    function automatic logic [15:0] readWord(
        input logic [7:0]  code,
        input csr_cfg_t    cfg,
        input logic [15:0] red,
        input logic [15:0] green,
        input logic [15:0] blue,
        input logic [15:0] white
    );
        case (code)
            // [RULE1] control word
            // [RULE6] reserved high byte
            `CMD_CONFIG: return {`RSVD_VALUE, cfg};
            // [RULE9] result per code
            `CMD_RED:    return red;
            `CMD_GREEN:  return green;
            `CMD_BLUE:   return blue;
            `CMD_WHITE:  return white;
            // [RULE7] reserved codes read zero
            default:     return {`RSVD_VALUE, `RSVD_VALUE};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // two-wire target

    always_comb begin
        next_r           = r;
        next_r.sclPrev   = scl;
        next_r.sdaPrev   = sda;
        next_r.trigPulse = 1'b0;
        // [RULE3] finished cycle clears trigger
        if (measDone) begin
            next_r.cfg.one_shot_trigger = 1'b0;
        end
        if (busStop) begin
            next_r.st    = LNK_IDLE;
            next_r.drive = 1'b0;
        end else if (busStart) begin
            // [RULE15] repeated start keeps pointer
            next_r.st     = LNK_RX;
            next_r.phase  = RX_ADDR;
            next_r.bitCnt = '0;
            next_r.drive  = 1'b0;
        end else begin
            case (r.st)
                LNK_RX: begin
                    if (sclRise && r.bitCnt != `BYTE_BITS) begin
                        next_r.shift  = {r.shift[6:0], sda};
                        next_r.bitCnt = r.bitCnt + 4'h1;
                    end else if (sclFall && r.bitCnt == `BYTE_BITS) begin
                        next_r.bitCnt = '0;
                        next_r.st     = LNK_ACK;
                        next_r.ret    = LNK_RX;
                        next_r.drive  = 1'b1;
                        case (r.phase)
                            RX_ADDR: begin
                                // [RULE13] match own address
                                if (r.shift[7:1] != `I2C_ADDR) begin
                                    next_r.st    = LNK_IGNORE;
                                    next_r.drive = 1'b0;
                                end else if (r.shift[0]) begin
                                    // [RULE11] word captured at read address
                                    next_r.ret    = LNK_TX;
                                    next_r.txHigh = 1'b0;
                                    next_r.rdWord = readWord(r.ptr, r.cfg, redResult, greenResult,
                                                             blueResult, whiteResult);
                                end else begin
                                    next_r.phase = RX_CMD;
                                end
                            end
                            RX_CMD: begin
                                next_r.ptr   = r.shift;
                                next_r.phase = RX_LOW;
                            end
                            RX_LOW: begin
                                next_r.wrLow = r.shift;
                                next_r.phase = RX_HIGH;
                            end
                            default: begin
                                // [RULE14] commit after high byte
                                next_r.ret = LNK_IGNORE;
                                if (r.ptr == `CMD_CONFIG) begin
                                    // [RULE1] control write
                                    // [RULE18] unused bits forced zero
                                    next_r.cfg       = csr_cfg_t'(r.wrLow & `CFG_WMASK);
                                    next_r.trigPulse = next_r.cfg.one_shot_trigger;
                                end
                            end
                        endcase
                    end
                end
                LNK_ACK: begin
                    if (sclFall) begin
                        next_r.st    = r.ret;
                        next_r.drive = 1'b0;
                        if (r.ret == LNK_TX) begin
                            // [RULE10] low byte first
                            next_r.txShift = r.rdWord[7:0];
                            next_r.drive   = !r.rdWord[7];
                        end
                    end
                end
                LNK_TX: begin
                    if (sclFall) begin
                        if (r.bitCnt == `BYTE_LAST) begin
                            next_r.st     = LNK_MACK;
                            next_r.bitCnt = '0;
                            next_r.drive  = 1'b0;
                        end else begin
                            next_r.txShift = {r.txShift[6:0], 1'b0};
                            next_r.drive   = !r.txShift[6];
                            next_r.bitCnt  = r.bitCnt + 4'h1;
                        end
                    end
                end
                LNK_MACK: begin
                    if (sclRise) begin
                        next_r.mackOk = !sda;
                    end
                    if (sclFall) begin
                        if (r.mackOk && !r.txHigh) begin
                            // [RULE10] high byte second
                            next_r.st      = LNK_TX;
                            next_r.txHigh  = 1'b1;
                            next_r.txShift = r.rdWord[15:8];
                            next_r.drive   = !r.rdWord[15];
                        end else begin
                            next_r.st = LNK_IGNORE;
                        end
                    end
                end
                LNK_IDLE, LNK_IGNORE: begin
                    next_r.drive = 1'b0;
                end
                default: begin
                    next_r.st    = LNK_IDLE;
                    next_r.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r         <= '0;
            r.cfg     <= csr_cfg_t'(`CFG_RESET);
            r.sclPrev <= 1'b1;
            r.sdaPrev <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut    = 1'b0;
    assign sdaOe     = r.drive;
    assign measuring = measBusy;
endmodule // csr_sensor_top

// ### shared/csr_defines.svh
// Behaviour
// [RULE1] one 16-bit control register at code zero
// [RULE2] integration field selects 40 to 1280 ms
// [RULE3] trigger bit starts exactly one measurement
// [RULE4] mode bit: zero auto, one forced
// [RULE5] shutdown bit: zero enabled, one disabled
// [RULE6] control high byte reserved, reads zero
// [RULE7] codes one to seven reserved, read zero
// [RULE8] four results, 16-bit, low and high byte
// [RULE9] codes eight to eleven: red green blue white
// [RULE10] word transfer sends low byte first
// [RULE11] host reads with repeated-start read-word sequence
// [RULE12] green scale follows integration time
// [RULE13] target answers seven-bit address sixteen
// [RULE14] host writes whole words, low then high
// [RULE15] host uses repeated start, no stop, reading
// [RULE16] results hold until next measurement completes
// [RULE17] auto mode measures continuously, updates all four
// [RULE18] host writes zero to unused bits
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

`define I2C_ADDR      7'h10
`define CMD_CONFIG    8'h00
`define CMD_RED       8'h08
`define CMD_GREEN     8'h09
`define CMD_BLUE      8'h0a
`define CMD_WHITE     8'h0b
`define CFG_RESET     8'h00
`define CFG_WMASK     8'h77
`define RSVD_VALUE    8'h00
`define BYTE_BITS     4'h8
`define BYTE_LAST     4'h7
`define COUNT_MAX     16'hffff
`define IT_MAX_CODE   3'h5
`define INT_BASE_MS   11'h028
`define MS_W          11
`define TICK_W        18
`define CLK_MHZ       200
`define TICK_US       1000

`endif

// ### shared/csr_pkg.sv
package csr_pkg;

    typedef struct packed {
        logic       zeroHi;
        logic [2:0] integration_time_sel;
        logic       zeroLo;
        logic       one_shot_trigger;
        logic       forced_mode_sel;
        logic       sensor_shutdown;
    } csr_cfg_t;

    typedef enum logic [2:0] {LNK_IDLE, LNK_RX, LNK_ACK, LNK_TX, LNK_MACK, LNK_IGNORE} csr_link_state_t;
    typedef enum logic [1:0] {RX_ADDR, RX_CMD, RX_LOW, RX_HIGH} csr_rx_phase_t;
    typedef enum logic {MEAS_IDLE, MEAS_RUN} csr_meas_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } csr_sync_regs_t;

    typedef struct packed {
        csr_meas_state_t   st;
        logic [17:0]       tick;
        logic              msTick;
        logic [10:0]       ms;
        logic [10:0]       msTarget;
        logic [3:0][15:0]  acc;
        logic [3:0][15:0]  res;
        logic              done;
    } csr_meas_regs_t;

    typedef struct packed {
        csr_link_state_t st;
        csr_link_state_t ret;
        csr_rx_phase_t   phase;
        logic [3:0]      bitCnt;
        logic [7:0]      shift;
        logic [7:0]      txShift;
        logic            txHigh;
        logic            mackOk;
        logic [15:0]     rdWord;
        logic [7:0]      ptr;
        logic [7:0]      wrLow;
        csr_cfg_t        cfg;
        logic            trigPulse;
        logic            drive;
        logic            sclPrev;
        logic            sdaPrev;
    } csr_link_regs_t;

endpackage

// ### logic/csr_pin_sync.sv
`timescale 1ns/100ps
module csr_pin_sync (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [1:0] pinIn,
    output logic      [1:0] pinSync
);
    import csr_pkg::*;

    csr_sync_regs_t r;
    csr_sync_regs_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = pinIn;
        next_r.s2 = r.s1;
    end

    // idle bus level is high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign pinSync = r.s2;
endmodule // csr_pin_sync

// ### logic/csr_meas_engine.sv
`timescale 1ns/100ps
`include "csr_defines.svh"
module csr_meas_engine #(
    parameter int TICK_CYCLES = `CLK_MHZ * `TICK_US
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        shutdown,
    input  wire logic        forced,
    input  wire logic [2:0]  itSel,
    input  wire logic        trigPulse,
    input  wire logic [3:0]  lightPulse,
    output logic      [15:0] redResult,
    output logic      [15:0] greenResult,
    output logic      [15:0] blueResult,
    output logic      [15:0] whiteResult,
    output logic             measDone,
    output logic             measBusy
);
    import csr_pkg::*;

    csr_meas_regs_t r;
    csr_meas_regs_t next_r;

    // [RULE2] code to milliseconds
    function automatic logic [10:0] itMs(input logic [2:0] code);
        if (code > `IT_MAX_CODE) begin
            return `INT_BASE_MS << `IT_MAX_CODE;
        end
        return `INT_BASE_MS << code;
    endfunction

    function automatic logic [15:0] satInc(input logic [15:0] v, input logic p);
        return (p && v != `COUNT_MAX) ? v + 16'h0001 : v;
    endfunction

    always_comb begin
        next_r        = r;
        next_r.done   = 1'b0;
        next_r.msTick = 1'b0;
        if (r.tick == `TICK_W'(TICK_CYCLES - 1)) begin
            next_r.tick   = '0;
            next_r.msTick = 1'b1;
        end else begin
            next_r.tick = r.tick + `TICK_W'(1);
        end
        case (r.st)
            MEAS_IDLE: begin
                // [RULE4] forced waits for trigger
                // [RULE17] auto restarts at once
                if (!shutdown && (!forced || trigPulse)) begin
                    next_r.st       = MEAS_RUN;
                    next_r.tick     = '0;
                    next_r.ms       = '0;
                    next_r.msTarget = itMs(itSel);
                    next_r.acc      = '0;
                end
            end
            MEAS_RUN: begin
                // [RULE5] shutdown aborts, results kept
                if (shutdown) begin
                    next_r.st = MEAS_IDLE;
                end else if (r.ms == r.msTarget) begin
                    // [RULE16] results change only here
                    next_r.res  = r.acc;
                    next_r.done = 1'b1;
                    next_r.st   = MEAS_IDLE;
                end else begin
                    // [RULE12] counts scale with window
                    for (int i = 0; i < 4; i++) begin
                        next_r.acc[i] = satInc(r.acc[i], lightPulse[i]);
                    end
                    if (r.msTick) begin
                        next_r.ms = r.ms + `MS_W'(1);
                    end
                end
            end
            default: next_r.st = MEAS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // [RULE8] four 16-bit results
    assign redResult   = r.res[0];
    assign greenResult = r.res[1];
    assign blueResult  = r.res[2];
    assign whiteResult = r.res[3];
    assign measDone    = r.done;
    assign measBusy    = (r.st == MEAS_RUN);
endmodule // csr_meas_engine

// ### bench/csr_host_model.sv
`timescale 1ns/100ps
module csr_host_model (
    input  wire logic clk_sys,
    input  wire logic sdaIn,
    output logic      sclOut,
    output logic      hostOe
);
    // quarter of a bus clock period in system clocks
    int qtr = 4;
    initial begin
        sclOut = 1'b1;
        hostOe = 1'b0;
    end
    task automatic q();
        repeat (qtr) @(negedge clk_sys);
    endtask
    task automatic start();
        hostOe = 1'b0;
        q();
        sclOut = 1'b1;
        q();
        hostOe = 1'b1;
        q();
        sclOut = 1'b0;
        q();
    endtask
    task automatic stop();
        hostOe = 1'b1;
        q();
        sclOut = 1'b1;
        q();
        hostOe = 1'b0;
        q();
    endtask
    task automatic clkBit(input logic b, output logic s);
        hostOe = !b;
        q();
        sclOut = 1'b1;
        q();
        s = sdaIn;
        q();
        sclOut = 1'b0;
        q();
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(d[i], s);
        end
        clkBit(1'b1, s);
        ack = !s;
    endtask
    task automatic rx(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(1'b1, s);
            d[i] = s;
        end
        clkBit(last, s);
    endtask
    task automatic writeWord(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, output logic ok);
        logic k0, k1, k2, k3;
        start();
        tx({a, 1'b0}, k0);
        tx(c, k1);
        tx(w[7:0], k2);
        tx(w[15:8], k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask
    task automatic readWord(input logic [6:0] a, input logic [7:0] c, output logic [15:0] w, output logic ok);
        logic k0, k1, k2;
        start();
        tx({a, 1'b0}, k0);
        tx(c, k1);
        start();
        tx({a, 1'b1}, k2);
        rx(1'b0, w[7:0]);
        rx(1'b1, w[15:8]);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule // csr_host_model

// ### bench/csr_sensor_monitor.sv
`timescale 1ns/100ps
module csr_sensor_monitor #(
    parameter int TICK_CYCLES = 200000
) (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic [3:0] lightPulse,
    input wire logic       measuring
);
    localparam int MAX_WIN = 1280 * TICK_CYCLES + 8;
    logic [7:0]  sclHist;
    logic [31:0] measCnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sclHist <= 8'hff;
            measCnt <= 32'h0000_0000;
        end else begin
            sclHist <= {sclHist[6:0], sclIn};
            measCnt <= measuring ? measCnt + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    sequence s_start;
        sclIn && $fell(sdaIn);
    endsequence
    sequence s_oe_hold;
        sdaOe [*8];
    endsequence
    a_start_quiet: assert property (s_start |-> !sdaOe [*8])
        else $error("sda pulled right after start");
    a_ack_hold: assert property ($rose(sdaOe) |=> s_oe_hold)
        else $error("driven low bit too short");
    a_release_hold: assert property ($fell(sdaOe) |=> !sdaOe [*8])
        else $error("released bit too short");
    a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn && (|sclHist[7:3]))
        else $error("sda changed outside early scl low");
    a_sda_zero: assert property (sdaOut == 1'b0)
        else $error("sda output not low");
    a_oe_boot: assert property (!$past(resetn) |-> !sdaOe)
        else $error("sda pulled at reset release");
    a_meas_boot: assert property ($rose(resetn) |-> ##[1:3] measuring)
        else $error("no measurement after reset");
    a_meas_bound: assert property (measuring |-> measCnt < MAX_WIN)
        else $error("measurement longer than longest window");
endmodule // csr_sensor_monitor
bind csr_sensor_top csr_sensor_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_csr_sensor_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .lightPulse(lightPulse), .measuring(measuring));

// ### bench/csr_sensor_top_tb_top.sv
`timescale 1ns/100ps
`include "csr_defines.svh"
module csr_sensor_top_tb_top;
    localparam int TICK = 4;
    logic       clk_sys = 1'b0;
    logic       resetn = 1'b0;
    logic       sclIn;
    logic       sdaOut;
    logic       sdaOe;
    logic       hostOe;
    logic       measuring;
    logic       pulseOn = 1'b0;
    logic [3:0] lightPulse = 4'h0;
    wire        sdaIn = !(sdaOe | hostOe);
    int         error_cnt = 0;
    int         checked = 0;
    int         cycles = 0;
    int         pcnt = 0;
    csr_sensor_top #(.TICK_CYCLES(TICK)) u_csr_sensor_top (
        .clk_sys(clk_sys), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .lightPulse(lightPulse), .measuring(measuring));
    csr_host_model u_csr_host_model (.clk_sys(clk_sys), .sdaIn(sdaIn), .sclOut(sclIn), .hostOe(hostOe));
    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            error_cnt++;
            $display("[FAIL] %0t run too long", $time);
            give_verdict();
        end
    end
    // front-end pulses only within a triggered window
    always @(negedge clk_sys) begin
        if (pulseOn && measuring) begin
            lightPulse <= {pcnt < 1000, pcnt < 128, pcnt < 515, pcnt < 261};
            pcnt <= pcnt + 1;
        end else begin
            lightPulse <= 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] w);
        logic ok;
        u_csr_host_model.writeWord(`I2C_ADDR, c, w, ok);
        check({15'h0000, ok}, 16'h0001, "write ack");
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] exp, input string what);
        logic [15:0] w;
        logic        ok;
        u_csr_host_model.readWord(`I2C_ADDR, c, w, ok);
        check({15'h0000, ok}, 16'h0001, "read ack");
        check(w, exp, what);
    endtask
    task automatic waitMeas(input logic lvl, input int limit);
        int n = 0;
        while (measuring !== lvl && n < limit) begin
            @(negedge clk_sys);
            n++;
        end
        check({15'h0000, measuring}, {15'h0000, lvl}, "measuring level");
    endtask
    task automatic pulseReset(input int n);
        resetn = 1'b0;
        repeat (n) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_defaults();
        rd(`CMD_CONFIG, 16'h0000, "config reset");
        for (int c = 1; c < 8; c++) begin
            rd(c[7:0], 16'h0000, "reserved read");
        end
        rd(`CMD_RED, 16'h0000, "result reset");
        waitMeas(1'b1, 8);
        $display("test defaults done");
    endtask
    task automatic test_config();
        logic ok;
        wr(`CMD_CONFIG, 16'hffff);
        rd(`CMD_CONFIG, 16'h0077, "unused bits masked");
        waitMeas(1'b0, 8);
        repeat (400) @(negedge clk_sys);
        check({15'h0000, measuring}, 16'h0000, "shut down stays idle");
        wr(8'h03, 16'habcd);
        rd(8'h03, 16'h0000, "reserved write dropped");
        wr(`CMD_RED, 16'h1234);
        rd(`CMD_RED, 16'h0000, "result read only");
        u_csr_host_model.writeWord(7'h11, `CMD_CONFIG, 16'h0000, ok);
        check({15'h0000, ok}, 16'h0000, "foreign address ack");
        rd(`CMD_CONFIG, 16'h0077, "foreign write ignored");
        wr(`CMD_CONFIG, 16'h0000);
        waitMeas(1'b1, 20);
        $display("test config done");
    endtask
    task automatic test_windows();
        int n;
        int win;
        for (int k = 0; k < 6; k++) begin
            win = (40 << k) * TICK;
            wr(`CMD_CONFIG, {9'h000, k[2:0], 4'h0});
            waitMeas(1'b0, 6000);
            waitMeas(1'b1, 8);
            n = 0;
            while (measuring === 1'b1 && n < 6000) begin
                @(negedge clk_sys);
                n++;
            end
            check({15'h0000, n >= win - 1 && n <= win + 4}, 16'h0001, "window length");
        end
        $display("test windows done");
    endtask
    task automatic test_forced();
        wr(`CMD_CONFIG, 16'h0032);
        waitMeas(1'b0, 6000);
        repeat (50) @(negedge clk_sys);
        check({15'h0000, measuring}, 16'h0000, "forced idle");
        pcnt = 0;
        pulseOn = 1'b1;
        wr(`CMD_CONFIG, 16'h0036);
        waitMeas(1'b1, 8);
        waitMeas(1'b0, 1400);
        pulseOn = 1'b0;
        rd(`CMD_RED, 16'h0105, "red count");
        rd(`CMD_GREEN, 16'h0203, "green count");
        rd(`CMD_BLUE, 16'h0080, "blue count");
        rd(`CMD_WHITE, 16'h03e8, "white count");
        rd(`CMD_CONFIG, 16'h0032, "trigger cleared");
        check({15'h0000, measuring}, 16'h0000, "single cycle only");
        wr(`CMD_CONFIG, 16'h0033);
        u_csr_host_model.qtr = 9;
        rd(`CMD_RED, 16'h0105, "result kept");
        rd(`CMD_WHITE, 16'h03e8, "result kept");
        u_csr_host_model.qtr = 4;
        $display("test forced done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        pulseReset(8);
        test_defaults();
        test_config();
        test_windows();
        test_forced();
        pulseReset(3);
        test_defaults();
        give_verdict();
    end
endmodule // csr_sensor_top_tb_top
